// [testbench/fwd_ctrl_chk.sv]
// Checker for the forwarding control bank outputs.
// Bound to fwd_ctrl_bank; sees only its ports.
`timescale 1ns/1ps
module fwd_ctrl_chk (
	// Clock, reset and status inputs
	input wire       clk_i,
	input wire       rst_i,
	input wire [6:0] fcbp_on_i,
	input wire [6:0] autoneg_pause_i,
	// Observed controls
	input wire [6:0] proc_port_o,
	input wire       egress_crc_append_o,
	input wire [6:0] bcast_to_proc_block_o,
	input wire [6:0] port_off_o,
	input wire [6:0] ucast_both_thr_o,
	input wire [6:0] mcast_both_thr_o,
	input wire [6:0] pause_on_o,
	input wire [6:0] backpressure_on_o,
	input wire [6:0] port_age_out_mask_o,
	input wire [1:0] backpressure_style_o,
	input wire       collision_backoff_select_o,
	input wire       encap_length_check_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_sel;
		$onehot(proc_port_o) && (proc_port_o & 7'h0e) == 7'h00;
	endproperty
	a_sel: assert property (p_sel) else $error("bad processor port");
	property p_bp;
		backpressure_style_o == 2'b00 |=> backpressure_on_o == 7'h00;
	endproperty
	a_bp: assert property (p_bp) else $error("bp while off");
	property p_pause;
		1'b1 |=> (pause_on_o & ~$past(autoneg_pause_i)) == 7'h00;
	endproperty
	a_pause: assert property (p_pause) else $error("pause");
	property p_uthr;
		fcbp_on_i == 7'h00 |=> ucast_both_thr_o == 7'h00;
	endproperty
	a_uthr: assert property (p_uthr) else $error("ucast thr");
	property p_mthr;
		fcbp_on_i == 7'h00 |=> mcast_both_thr_o == 7'h00;
	endproperty
	a_mthr: assert property (p_mthr) else $error("mcast thr");
	property p_off;
		$fell(rst_i) |-> port_off_o == 7'h7f && proc_port_o == 7'h40;
	endproperty
	a_off: assert property (p_off) else $error("reset ports");
	property p_msk;
		$fell(rst_i) |-> (bcast_to_proc_block_o & port_age_out_mask_o) == 7'h7f;
	endproperty
	a_msk: assert property (p_msk) else $error("reset masks");
	property p_glb;
		$fell(rst_i) |-> egress_crc_append_o && collision_backoff_select_o
			&& encap_length_check_o && backpressure_style_o == 2'b10;
	endproperty
	a_glb: assert property (p_glb) else $error("reset bits");
endmodule // fwd_ctrl_chk
bind fwd_ctrl_bank fwd_ctrl_chk u_chk (.*);

// [testbench/fwd_far_end.sv]
// Far-side model: port MAC and forwarding engine status toward the bank.
// Bench commands are launched on the next rising edge of clk_i.
`timescale 1ns/1ps
module fwd_far_end (
	// Clock
	input  wire       clk_i,
	// Bench commands
	input  wire [1:0] clk_on_i,
	input  wire [6:0] bad_src_i,
	input  wire [6:0] fc_i,
	input  wire [6:0] an_i,
	// Status toward the bank
	output reg  [1:0] tx_clock_seen_o,
	output reg  [6:0] illegal_src_o,
	output reg  [6:0] fcbp_on_o,
	output reg  [6:0] autoneg_pause_o
);
	initial begin
		tx_clock_seen_o = 2'b11;
		illegal_src_o   = 7'h00;
		fcbp_on_o       = 7'h00;
		autoneg_pause_o = 7'h00;
	end
	always @(posedge clk_i) begin
		tx_clock_seen_o <= clk_on_i;
		illegal_src_o   <= bad_src_i;
		fcbp_on_o       <= fc_i;
		autoneg_pause_o <= an_i;
	end
endmodule // fwd_far_end

// [testbench/tb.sv]
// Bench for the forwarding control bank: Wishbone tasks and checks.
// Far side comes from fwd_far_end; short blink periods are set.
`timescale 1ns/1ps
`include "fwd_ctrl_consts.vh"
module tb;
	reg         clk_i, rst_i, cyc_i, stb_i, we_i;
	reg  [7:0]  adr_i;
	reg  [3:0]  sel_i;
	reg  [31:0] dat_i, q, d;
	reg  [31:0] rv [0:6], mk [0:6];
	reg  [1:0]  clk_on;
	reg  [6:0]  bad, fc, an;
	reg         l;
	integer     i, c, n, n_errors, num_checks;
	wire [31:0] dat_o;
	wire        ack_o, egress_crc_append_o, vlan_table_tag_strip_sel_o;
	wire        listener_msgs_proc_only_o, collision_backoff_select_o;
	wire        encap_length_check_o, lamp_blink_o;
	wire [1:0]  tx_clock_seen_i, v6_unknown_group_action_o;
	wire [1:0]  v4_unknown_group_action_o, resv_group_action_o;
	wire [1:0]  backpressure_style_o;
	wire [6:0]  illegal_src_i, fcbp_on_i, autoneg_pause_i, proc_port_o;
	wire [6:0]  bcast_to_proc_block_o, mcast_to_proc_block_o, blocking_o;
	wire [6:0]  unknown_ucast_to_proc_block_o, resv_mcast_to_proc_block_o;
	wire [6:0]  ip_mcast_to_proc_block_o, port_off_o, ucast_both_thr_o;
	wire [6:0]  mcast_both_thr_o, pause_on_o, backpressure_on_o, tag_strip_o;
	wire [6:0]  learn_off_mask_o, source_lock_mask_o, ucast_pause_ignore_o;
	wire [6:0]  port_age_out_mask_o;
	wire [89:0] dir = {bcast_to_proc_block_o, mcast_to_proc_block_o,
		unknown_ucast_to_proc_block_o, resv_mcast_to_proc_block_o,
		ip_mcast_to_proc_block_o, blocking_o, learn_off_mask_o,
		source_lock_mask_o, ucast_pause_ignore_o, tag_strip_o,
		port_age_out_mask_o, vlan_table_tag_strip_sel_o, egress_crc_append_o,
		listener_msgs_proc_only_o, collision_backoff_select_o,
		encap_length_check_o, v6_unknown_group_action_o,
		v4_unknown_group_action_o, resv_group_action_o, backpressure_style_o};
	fwd_ctrl_bank #(.BLINK_CYC_0(27'd4), .BLINK_CYC_1(27'd8),
		.BLINK_CYC_2(27'd16), .BLINK_CYC_3(27'd32)) DUT (.*);
	fwd_far_end far (.clk_i(clk_i), .clk_on_i(clk_on), .bad_src_i(bad),
		.fc_i(fc), .an_i(an), .tx_clock_seen_o(tx_clock_seen_i),
		.illegal_src_o(illegal_src_i), .fcbp_on_o(fcbp_on_i),
		.autoneg_pause_o(autoneg_pause_i));
	task bus(input [7:0] a, input w, input [31:0] v);
		integer k;
		begin
			@(posedge clk_i);
			cyc_i <= 1'b1;
			stb_i <= 1'b1;
			we_i <= w;
			adr_i <= a;
			dat_i <= v;
			k = 0;
			@(posedge clk_i);
			while (ack_o !== 1'b1 && k < 50) begin
				@(posedge clk_i);
				k = k + 1;
			end
			q = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			if (k == 50) n_errors = n_errors + 1;
		end
	endtask
	task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("unexpected %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task settle;
		begin
			repeat (3) @(posedge clk_i);
			#1;
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		n_errors = n_errors + 1;
		finish_test;
	end
	initial begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, bad, fc, an} = 0;
		rst_i = 1'b1;
		sel_i = 4'hf;
		clk_on = 2'b11;
		n_errors = 0;
		num_checks = 0;
		rv[0] = 0;
		rv[1] = `RST_SOC_PORT;
		rv[2] = `RST_PORT_CTL0;
		rv[3] = `RST_PORT_CTL1;
		rv[4] = `RST_PORT_CTL2;
		rv[5] = `RST_GLOBAL;
		rv[6] = 0;
		mk[0] = 0;
		mk[1] = `MSK_SOC_PORT;
		mk[2] = `MSK_PORT_CTL0;
		mk[3] = `MSK_PORT_CTL1;
		mk[4] = `MSK_PORT_CTL2;
		mk[5] = `MSK_GLOBAL;
		mk[6] = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 7; i = i + 1) begin
			bus(8'h88 + 4 * i, 1'b0, 0);
			chk("reset", rv[i], q);
		end
		for (c = 0; c < 2; c = c + 1) begin
			d = c ? 32'h0 : 32'hffff_ffff;
			for (i = 0; i < 7; i = i + 1)
				bus(8'h88 + 4 * i, 1'b1, d);
			for (i = 0; i < 7; i = i + 1) begin
				bus(8'h88 + 4 * i, 1'b0, 0);
				chk("readback", d & mk[i], q);
			end
			chk("direct", 1, c ? ~|dir : &dir);
			chk("mid", 1, c ? ~|dir[33:12] : &dir[33:12]);
			chk("lo", 1, c ? ~|dir[7:0] : &dir[7:0]);
		end
		for (c = 0; c < 4; c = c + 1) begin
			bus(`OFS_SOC_PORT, 1'b1, c << 23);
			settle;
			chk("proc port", 32'h2010_0140 >> (8 * c) & 7'h7f, proc_port_o);
		end
		chk("crc", 0, egress_crc_append_o);
		bus(`OFS_PORT_CTL2, 1'b1, 32'h2000_0000);
		clk_on <= 2'b00;
		settle;
		chk("watch", 7'h20, port_off_o);
		bus(`OFS_PORT_STATUS, 1'b0, 0);
		chk("tx clock", 32'h300, q);
		clk_on <= 2'b11;
		bus(`OFS_PORT_CTL0, 1'b1, 32'h2000_0f7f);
		settle;
		chk("off", 7'h40, port_off_o);
		bus(`OFS_PORT_CTL1, 1'b1, 32'h0000_0505);
		bad <= 7'h7f;
		@(posedge clk_i);
		bad <= 7'h00;
		bus(`OFS_PORT_STATUS, 1'b0, 0);
		chk("flags", 32'h5, q);
		bus(`OFS_PORT_STATUS, 1'b0, 0);
		chk("flags clr", 32'h0, q);
		fc <= 7'h02;
		an <= 7'h7f;
		bus(`OFS_SOC_PORT, 1'b1, 32'h0000_8000);
		settle;
		chk("uc thr", 7'h02, ucast_both_thr_o);
		chk("mc thr", 7'h7f, mcast_both_thr_o);
		chk("pause", 7'h0f, pause_on_o);
		chk("bp off", 7'h00, backpressure_on_o);
		bus(`OFS_GLOBAL, 1'b1, 32'h0004_0000);
		settle;
		chk("bp on", 7'h7f, backpressure_on_o);
		for (c = 0; c < 4; c = c + 1) begin
			bus(`OFS_GLOBAL, 1'b1, c << 23);
			repeat (2) begin
				l = lamp_blink_o;
				n = 0;
				while (lamp_blink_o === l && n < 200) begin
					@(posedge clk_i);
					n = n + 1;
				end
			end
			chk("blink", 4 << c, n);
		end
		finish_test;
	end
endmodule // tb

// [verilog/fwd_ctrl_bank.v]
// Port and forwarding control register bank of a seven-port switch.
// Assumes a classic Wishbone master on clk_i and status inputs
// synchronous to clk_i from the forwarding engine and port MACs.
`timescale 1ns/1ps
`include "fwd_ctrl_consts.vh"

module fwd_ctrl_bank #(
	parameter [26:0] BLINK_CYC_0 = `BLINK_MS_0 * `CLK_KHZ,
	parameter [26:0] BLINK_CYC_1 = `BLINK_MS_1 * `CLK_KHZ,
	parameter [26:0] BLINK_CYC_2 = `BLINK_MS_2 * `CLK_KHZ,
	parameter [26:0] BLINK_CYC_3 = `BLINK_MS_3 * `CLK_KHZ
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire        ack_o,
	// Port status from MACs and forwarding engine
	input  wire [1:0]  tx_clock_seen_i,
	input  wire [6:0]  illegal_src_i,
	input  wire [6:0]  fcbp_on_i,
	input  wire [6:0]  autoneg_pause_i,
	// Processor port
	output wire [6:0]  proc_port_o,
	output wire        egress_crc_append_o,
	output wire [6:0]  bcast_to_proc_block_o,
	output wire [6:0]  mcast_to_proc_block_o,
	output wire [6:0]  unknown_ucast_to_proc_block_o,
	output wire [6:0]  resv_mcast_to_proc_block_o,
	output wire [6:0]  ip_mcast_to_proc_block_o,
	// Per-port control
	output wire [6:0]  port_off_o,
	output wire [6:0]  ucast_both_thr_o,
	output wire [6:0]  mcast_both_thr_o,
	output wire [6:0]  pause_on_o,
	output wire [6:0]  backpressure_on_o,
	output wire [6:0]  blocking_o,
	output wire [6:0]  learn_off_mask_o,
	output wire [6:0]  source_lock_mask_o,
	output wire [6:0]  ucast_pause_ignore_o,
	output wire [6:0]  tag_strip_o,
	output wire        vlan_table_tag_strip_sel_o,
	output wire [6:0]  port_age_out_mask_o,
	// Global forwarding and MAC control
	output wire        listener_msgs_proc_only_o,
	output wire [1:0]  v6_unknown_group_action_o,
	output wire [1:0]  v4_unknown_group_action_o,
	output wire [1:0]  resv_group_action_o,
	output wire [1:0]  backpressure_style_o,
	output wire        collision_backoff_select_o,
	output wire        encap_length_check_o,
	output wire        lamp_blink_o
);

	reg  [31:0] soc_q;
	reg  [31:0] ctl0_q;
	reg  [31:0] ctl1_q;
	reg  [31:0] ctl2_q;
	reg  [31:0] glb_q;
	reg  [6:0]  illegal_source_flags_q;
	reg  [31:0] dat_q;
	reg         ack_q;
	reg  [6:0]  proc_port_q;
	reg  [6:0]  port_off_q;
	reg  [6:0]  uc_thr_q;
	reg  [6:0]  mc_thr_q;
	reg  [6:0]  pause_q;
	reg  [6:0]  bp_q;
	reg  [26:0] blink_cnt_q;
	reg         blink_q;
	reg  [31:0] rd_d;
	reg  [26:0] blink_lim;
	wire [31:0] byte_msk;
	wire        req;
	wire        wr;
	wire        rd_status;
	wire        p6_tx_clock_missing;
	wire        p5_tx_clock_missing;
	wire [1:0]  psel;
	wire [1:0]  bp_style;

	assign byte_msk = {{8{sel_i[3]}}, {8{sel_i[2]}},
		{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign req = cyc_i & stb_i & ~ack_q;
	assign wr = req & we_i;
	assign rd_status = req & ~we_i & (adr_i == `OFS_PORT_STATUS);
	assign p6_tx_clock_missing = ~tx_clock_seen_i[1];
	assign p5_tx_clock_missing = ~tx_clock_seen_i[0];
	assign psel = soc_q[24:23];
	assign bp_style = glb_q[19:18];

	// Bus handshake: ack one cycle after request, then drops
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req & ~we_i)
				dat_q <= rd_d;
		end
	end

	// Read mux; unmapped and reserved bits read zero
	always @* begin
		case (adr_i)
		`OFS_PORT_STATUS: rd_d = {22'h00_0000,
			p6_tx_clock_missing, p5_tx_clock_missing,
			1'b0, illegal_source_flags_q};
		`OFS_SOC_PORT:    rd_d = soc_q & `MSK_SOC_PORT;
		`OFS_PORT_CTL0:   rd_d = ctl0_q & `MSK_PORT_CTL0;
		`OFS_PORT_CTL1:   rd_d = ctl1_q & `MSK_PORT_CTL1;
		`OFS_PORT_CTL2:   rd_d = ctl2_q & `MSK_PORT_CTL2;
		`OFS_GLOBAL:      rd_d = glb_q & `MSK_GLOBAL;
		default:          rd_d = 32'h0000_0000;
		endcase
	end

	// Register writes honour byte lanes and writable masks
	always @(posedge clk_i) begin
		if (rst_i) begin
			soc_q  <= `RST_SOC_PORT;
			ctl0_q <= `RST_PORT_CTL0;
			ctl1_q <= `RST_PORT_CTL1;
			ctl2_q <= `RST_PORT_CTL2;
			glb_q  <= `RST_GLOBAL;
		end else if (wr) begin
			case (adr_i)
			`OFS_SOC_PORT: soc_q <= (soc_q & ~(`MSK_SOC_PORT & byte_msk))
				| (dat_i & `MSK_SOC_PORT & byte_msk);
			`OFS_PORT_CTL0: ctl0_q <= (ctl0_q & ~(`MSK_PORT_CTL0 & byte_msk))
				| (dat_i & `MSK_PORT_CTL0 & byte_msk);
			`OFS_PORT_CTL1: ctl1_q <= (ctl1_q & ~(`MSK_PORT_CTL1 & byte_msk))
				| (dat_i & `MSK_PORT_CTL1 & byte_msk);
			`OFS_PORT_CTL2: ctl2_q <= (ctl2_q & ~(`MSK_PORT_CTL2 & byte_msk))
				| (dat_i & `MSK_PORT_CTL2 & byte_msk);
			`OFS_GLOBAL: glb_q <= (glb_q & ~(`MSK_GLOBAL & byte_msk))
				| (dat_i & `MSK_GLOBAL & byte_msk);
			default: ;
			endcase
		end
	end

	// Per-port sticky flags and policy outputs
	genvar i;
	generate
		for (i = 0; i < 7; i = i + 1) begin : g_port
			wire hit;
			assign hit = illegal_src_i[i] & ctl1_q[i];
			always @(posedge clk_i) begin
				if (rst_i) begin
					illegal_source_flags_q[i] <= 1'b0;
					uc_thr_q[i] <= 1'b0;
					mc_thr_q[i] <= 1'b0;
					pause_q[i]  <= 1'b0;
					bp_q[i]     <= 1'b0;
				end else begin
					// Set beats the read clear
					if (hit)
						illegal_source_flags_q[i] <= 1'b1;
					else if (rd_status)
						illegal_source_flags_q[i] <= 1'b0;
					uc_thr_q[i] <= soc_q[`B_UC_POLICY] ?
						fcbp_on_i[i] : |fcbp_on_i;
					mc_thr_q[i] <= ctl0_q[`B_MC_POLICY] ?
						fcbp_on_i[i] : |fcbp_on_i;
					pause_q[i] <= ctl0_q[8 + i] & autoneg_pause_i[i];
					bp_q[i] <= ctl0_q[i] & (bp_style != `BP_OFF);
				end
			end
		end
	endgenerate

	// Processor port decode and effective port disables
	always @(posedge clk_i) begin
		if (rst_i) begin
			proc_port_q <= 7'h40;
			port_off_q  <= 7'h7f;
		end else begin
			case (psel)
			`PSEL_P6: proc_port_q <= 7'h40;
			`PSEL_P0: proc_port_q <= 7'h01;
			`PSEL_P4: proc_port_q <= 7'h10;
			`PSEL_P5: proc_port_q <= 7'h20;
			default:  proc_port_q <= 7'h40;
			endcase
			port_off_q[4:0] <= ctl0_q[27:23];
			port_off_q[5] <= ctl0_q[`B_P5_DIS] | (ctl2_q[`B_P5_TXC_WATCH]
				& p5_tx_clock_missing);
			port_off_q[6] <= ctl0_q[`B_P6_DIS] | (ctl2_q[`B_P6_TXC_WATCH]
				& p6_tx_clock_missing);
		end
	end

	// Blink period select
	always @* begin
		case (glb_q[24:23])
		2'b00:   blink_lim = BLINK_CYC_0;
		2'b01:   blink_lim = BLINK_CYC_1;
		2'b10:   blink_lim = BLINK_CYC_2;
		2'b11:   blink_lim = BLINK_CYC_3;
		default: blink_lim = BLINK_CYC_0;
		endcase
	end

	// Lamp toggles once per period
	always @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_q <= 27'h000_0000;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q >= blink_lim - 27'h000_0001) begin
			blink_cnt_q <= 27'h000_0000;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 27'h000_0001;
		end
	end

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign proc_port_o = proc_port_q;
	assign egress_crc_append_o = soc_q[`B_CRC_PAD];
	assign bcast_to_proc_block_o = soc_q[22:16];
	assign mcast_to_proc_block_o = soc_q[14:8];
	assign unknown_ucast_to_proc_block_o = soc_q[6:0];
	assign resv_mcast_to_proc_block_o = ctl0_q[22:16];
	assign ip_mcast_to_proc_block_o = ctl1_q[29:23];
	assign port_off_o = port_off_q;
	assign ucast_both_thr_o = uc_thr_q;
	assign mcast_both_thr_o = mc_thr_q;
	assign pause_on_o = pause_q;
	assign backpressure_on_o = bp_q;
	assign blocking_o = ctl1_q[22:16];
	assign learn_off_mask_o = ctl1_q[14:8];
	assign source_lock_mask_o = ctl1_q[6:0];
	assign ucast_pause_ignore_o = ctl2_q[22:16];
	assign tag_strip_o = ctl2_q[6:0];
	assign vlan_table_tag_strip_sel_o = ctl2_q[`B_STRIP_SEL];
	assign port_age_out_mask_o = ctl2_q[14:8];
	assign listener_msgs_proc_only_o = ctl2_q[`B_LISTENER];
	assign v6_unknown_group_action_o = ctl2_q[24:23];
	assign v4_unknown_group_action_o = glb_q[28:27];
	assign resv_group_action_o = glb_q[26:25];
	assign backpressure_style_o = bp_style;
	assign collision_backoff_select_o = glb_q[`B_BACKOFF];
	assign encap_length_check_o = glb_q[`B_LEN_CHECK];
	assign lamp_blink_o = blink_q;

endmodule // fwd_ctrl_bank

// [verilog/fwd_ctrl_consts.vh]
// Offsets, masks, reset values and timing for the forwarding control bank.
// Included by the bank module; holds definitions only.
`ifndef FWD_CTRL_CONSTS_VH
`define FWD_CTRL_CONSTS_VH

// Byte addresses (word aligned)
`define OFS_PORT_STATUS   8'h88
`define OFS_SOC_PORT      8'h8c
`define OFS_PORT_CTL0     8'h90
`define OFS_PORT_CTL1     8'h94
`define OFS_PORT_CTL2     8'h98
`define OFS_GLOBAL        8'h9c

// Writable bits; all others are reserved or read-only
`define MSK_SOC_PORT      32'h03ff_ff7f
`define MSK_PORT_CTL0     32'hffff_7fff
`define MSK_PORT_CTL1     32'h3fff_7f7f
`define MSK_PORT_CTL2     32'h63ff_ff7f
`define MSK_GLOBAL        32'h7fef_ffff

// Reset values
`define RST_SOC_PORT      32'h027f_7f7f
`define RST_PORT_CTL0     32'h3f80_7f7f
`define RST_PORT_CTL1     32'h0000_0000
`define RST_PORT_CTL2     32'h0000_7f00
`define RST_GLOBAL        32'h6008_a041

// Field positions
`define B_P6_TXC_MISS     9
`define B_P5_TXC_MISS     8
`define B_CRC_PAD         25
`define B_UC_POLICY       15
`define B_MC_POLICY       7
`define B_P6_DIS          29
`define B_P5_DIS          28
`define B_P6_TXC_WATCH    30
`define B_P5_TXC_WATCH    29
`define B_LISTENER        25
`define B_STRIP_SEL       15
`define B_BACKOFF         30
`define B_LEN_CHECK       29

// Processor port select codes
`define PSEL_P6           2'b00
`define PSEL_P0           2'b01
`define PSEL_P4           2'b10
`define PSEL_P5           2'b11

// Back-pressure style codes
`define BP_OFF            2'b00

// Blink periods in ms and clock rate in kHz
`define CLK_KHZ           250000
`define BLINK_MS_0        30
`define BLINK_MS_1        60
`define BLINK_MS_2        240
`define BLINK_MS_3        480

`endif
